// [hw/gpps_defines.svh]
// Register offsets, field positions and constants of the sensing I/O port
`ifndef GPPS_DEFINES_SVH
`define GPPS_DEFINES_SVH

// ==========================================
// Register byte addresses
`define GPPS_DIR 8'h00
`define GPPS_DIRSET 8'h04
`define GPPS_DIRCLR 8'h08
`define GPPS_DIRTGL 8'h0C
`define GPPS_OUT 8'h10
`define GPPS_OUTSET 8'h14
`define GPPS_OUTCLR 8'h18
`define GPPS_OUTTGL 8'h1C
`define GPPS_IN 8'h20
`define GPPS_INTCTRL 8'h24
`define GPPS_INT0MASK 8'h28
`define GPPS_INT1MASK 8'h2C
`define GPPS_INTFLAGS 8'h30
`define GPPS_MPCMASK 8'h34
`define GPPS_FUNCTRL 8'h38
`define GPPS_PINCTRL0 8'h40
`define GPPS_PINCTRL7 8'h5C
// Bit-accessible alias window
`define GPPS_VDIR 8'h80
`define GPPS_VOUT 8'h84
`define GPPS_VIN 8'h88
`define GPPS_VINTFLAGS 8'h8C

// ==========================================
// Pin control fields
`define GPPS_PC_SENSE 1:0
`define GPPS_PC_OPC 4:2
`define GPPS_PC_INV 5
`define GPPS_PC_W 6
// Function control fields
`define GPPS_FUN_CLK_EN 0
`define GPPS_FUN_CLK_PIN 3:1
`define GPPS_FUN_EV_EN 4
`define GPPS_FUN_EV_PIN 7:5
// Interrupt control fields
`define GPPS_ICTL_LVL0 1:0
`define GPPS_ICTL_LVL1 3:2

// ==========================================
// Interrupt vectors, word addresses
`define GPPS_PORT_C_VECTOR_BASE 12'h004
`define GPPS_INT0_VEC_OFS 12'h000
`define GPPS_INT1_VEC_OFS 12'h002

`endif

// [hw/gpps_pkg.sv]
// Types shared by the sensing I/O port
`default_nettype none

package gpps_pkg;
    // Input sense configuration
    typedef enum logic [1:0] {
        GPPS_SENSE_BOTH = 2'h0,
        GPPS_SENSE_RISE = 2'h1,
        GPPS_SENSE_FALL = 2'h2,
        GPPS_SENSE_LOW = 2'h3
    } gpps_sense_e;

    // Output driver configuration
    typedef enum logic [2:0] {
        GPPS_OPC_TOTEM = 3'h0,
        GPPS_OPC_KEEPER = 3'h1,
        GPPS_OPC_PULLDOWN = 3'h2,
        GPPS_OPC_PULLUP = 3'h3,
        GPPS_OPC_WOR = 3'h4,
        GPPS_OPC_WOR_PD = 3'h5,
        GPPS_OPC_WAND = 3'h6,
        GPPS_OPC_WAND_PU = 3'h7
    } gpps_opc_e;
endpackage

`default_nettype wire

// [hw/gpps_sense.sv]
// Per-pin input synchroniser, inversion and edge/level sensing
`default_nettype none

module gpps_sense (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pin and configuration
    input wire logic pin_raw,
    input wire logic invert,
    input wire logic [1:0] sense,
    input wire logic clk_en,
    // Results
    output logic pin_val,
    output logic pin_sync,
    output logic hit,
    output logic wake
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic wake;
    } gpps_sense_s;

    gpps_sense_s q, d;
    logic cond;

    // ==========================================
    // Sensing
    always_comb begin
        d = q;
        d.s1 = pin_raw;
        d.s2 = q.s1;
        pin_sync = q.s2;
        pin_val = q.s2 ^ invert;
        d.prev = pin_val;
        case (gpps_pkg::gpps_sense_e'(sense))
            gpps_pkg::GPPS_SENSE_BOTH: cond = pin_val != q.prev;
            gpps_pkg::GPPS_SENSE_RISE: cond = pin_val && !q.prev;
            gpps_pkg::GPPS_SENSE_FALL: cond = !pin_val && q.prev;
            default: cond = !pin_val;
        endcase
        // Port clock running: detections go to flags and events
        hit = clk_en && cond;
        // Port clock stopped: any sense condition raises wake-up
        d.wake = !clk_en && (cond || q.wake);
        wake = q.wake;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ==========================================
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_rise_hit: assert property (clk_en && sense == 2'h1 && $rose(pin_val) |-> hit)
        else $error("rising edge not sensed");
    a_low_wake: assert property (!clk_en && sense == 2'h3 && !pin_val |=> wake)
        else $error("low level did not wake");
endmodule

`default_nettype wire

// [hw/gpps_port.sv]
// Eight-pin general-purpose I/O port with sensing and an APB register slave
`include "gpps_defines.svh"
`default_nettype none

module gpps_port #(
    parameter int NPINS = 8
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Port pins
    input wire logic [NPINS-1:0] PORT_PIN_IN,
    output logic [NPINS-1:0] PORT_PIN_OUT,
    output logic [NPINS-1:0] PORT_PIN_OE_N,
    output logic [NPINS-1:0] PORT_PIN_PULL_UP,
    output logic [NPINS-1:0] PORT_PIN_PULL_DOWN,
    // Alternate functions and internal sources
    input wire logic [NPINS-1:0] ALT_EN,
    input wire logic [NPINS-1:0] ALT_OUT,
    input wire logic [NPINS-1:0] ALT_OE,
    input wire logic CLK_OUT_LEVEL,
    input wire logic EVCH7_LEVEL,
    input wire logic PORT_CLK_EN,
    // Interrupts, events and wake-up
    output logic INT0_REQ,
    output logic INT1_REQ,
    output logic [1:0] INT0_LEVEL,
    output logic [1:0] INT1_LEVEL,
    output logic [11:0] INT0_VECTOR,
    output logic [11:0] INT1_VECTOR,
    output logic [NPINS-1:0] SENSE_EVENT,
    output logic WAKE_REQ
);
    typedef struct packed {
        logic [NPINS-1:0] dir;
        logic [NPINS-1:0] out;
        logic [NPINS-1:0] in;
        logic [NPINS-1:0] m0;
        logic [NPINS-1:0] m1;
        logic [NPINS-1:0] mpc;
        logic [NPINS-1:0] keep;
        logic [NPINS-1:0] evt;
        logic [NPINS-1:0] pin_out;
        logic [NPINS-1:0] pin_oe_n;
        logic [NPINS-1:0] pu;
        logic [NPINS-1:0] pd;
        logic [NPINS-1:0][`GPPS_PC_W-1:0] pc;
        logic [1:0] flags;
        logic [3:0] ictl;
        logic [7:0] fun;
        logic int0;
        logic int1;
        logic wake;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [11:0] vec0;
        logic [11:0] vec1;
    } gpps_port_s;

    gpps_port_s q, d;

    logic [NPINS-1:0] pin_val;
    logic [NPINS-1:0] pin_sync;
    logic [NPINS-1:0] hit;
    logic [NPINS-1:0] wk;

    // ==========================================
    // Per-pin input path
    for (genvar g = 0; g < NPINS; g++) begin : g_pin
        gpps_sense u_sense (
            .clk(CLOCK),
            .rst(RST),
            .pin_raw(PORT_PIN_IN[g]),
            .invert(q.pc[g][`GPPS_PC_INV]),
            .sense(q.pc[g][`GPPS_PC_SENSE]),
            .clk_en(PORT_CLK_EN),
            .pin_val(pin_val[g]),
            .pin_sync(pin_sync[g]),
            .hit(hit[g]),
            .wake(wk[g])
        );
    end

    // ==========================================
    // Registers, interrupts and pin drivers
    logic setup;
    logic wr;
    logic [7:0] wd;
    logic [7:0] rv;
    logic [1:0] clr;
    logic [1:0] set;
    logic v;
    logic oe;
    logic drive;
    logic [2:0] pidx;

    always_comb begin
        d = q;
        rv = 8'h00;
        clr = 2'h0;
        v = 1'b0;
        oe = 1'b0;
        drive = 1'b0;
        setup = PSEL && !PENABLE;
        wr = PSEL && PENABLE && q.pready && PWRITE;
        wd = PWDATA[7:0];
        pidx = PADDR[4:2];
        d.pready = setup;
        d.pslverr = 1'b0;
        d.in = pin_val;
        d.evt = hit;

        // Read data is latched in the setup cycle, so every access is zero-wait
        if (setup) begin
            d.pslverr = 1'b0;
            if (PADDR == `GPPS_DIR || PADDR == `GPPS_VDIR) begin
                rv = q.dir;
            end else if (PADDR == `GPPS_OUT || PADDR == `GPPS_VOUT) begin
                rv = q.out;
            end else if (PADDR == `GPPS_IN || PADDR == `GPPS_VIN) begin
                rv = q.in;
            end else if (PADDR == `GPPS_INTFLAGS || PADDR == `GPPS_VINTFLAGS) begin
                rv = {6'h00, q.flags};
            end else if (PADDR == `GPPS_DIRSET || PADDR == `GPPS_DIRCLR
                         || PADDR == `GPPS_DIRTGL) begin
                rv = q.dir;
            end else if (PADDR == `GPPS_OUTSET || PADDR == `GPPS_OUTCLR
                         || PADDR == `GPPS_OUTTGL) begin
                rv = q.out;
            end else if (PADDR == `GPPS_INTCTRL) begin
                rv = {4'h0, q.ictl};
            end else if (PADDR == `GPPS_INT0MASK) begin
                rv = q.m0;
            end else if (PADDR == `GPPS_INT1MASK) begin
                rv = q.m1;
            end else if (PADDR == `GPPS_MPCMASK) begin
                rv = q.mpc;
            end else if (PADDR == `GPPS_FUNCTRL) begin
                rv = q.fun;
            end else if (PADDR >= `GPPS_PINCTRL0 && PADDR <= `GPPS_PINCTRL7
                         && PADDR[1:0] == 2'h0) begin
                rv = {2'h0, q.pc[pidx]};
            end else begin
                d.pslverr = 1'b1;
            end
            d.prdata = {24'h000000, rv};
        end

        // Writes take effect at the completing access edge
        if (wr) begin
            if (PADDR == `GPPS_DIR || PADDR == `GPPS_VDIR) begin
                d.dir = wd;
            end else if (PADDR == `GPPS_DIRSET) begin
                d.dir = q.dir | wd;
            end else if (PADDR == `GPPS_DIRCLR) begin
                d.dir = q.dir & ~wd;
            end else if (PADDR == `GPPS_DIRTGL) begin
                d.dir = q.dir ^ wd;
            end else if (PADDR == `GPPS_OUT || PADDR == `GPPS_VOUT) begin
                d.out = wd;
            end else if (PADDR == `GPPS_OUTSET) begin
                d.out = q.out | wd;
            end else if (PADDR == `GPPS_OUTCLR) begin
                d.out = q.out & ~wd;
            end else if (PADDR == `GPPS_OUTTGL) begin
                d.out = q.out ^ wd;
            end else if (PADDR == `GPPS_INTFLAGS || PADDR == `GPPS_VINTFLAGS) begin
                clr = PWDATA[1:0];
            end else if (PADDR == `GPPS_INTCTRL) begin
                d.ictl = PWDATA[3:0];
            end else if (PADDR == `GPPS_INT0MASK) begin
                d.m0 = wd;
            end else if (PADDR == `GPPS_INT1MASK) begin
                d.m1 = wd;
            end else if (PADDR == `GPPS_MPCMASK) begin
                d.mpc = wd;
            end else if (PADDR == `GPPS_FUNCTRL) begin
                d.fun = wd;
            end else if (PADDR >= `GPPS_PINCTRL0 && PADDR <= `GPPS_PINCTRL7
                         && PADDR[1:0] == 2'h0) begin
                // A pending multi-pin mask redirects the write to every masked pin
                if (q.mpc != '0) begin
                    for (int i = 0; i < NPINS; i++) begin
                        if (q.mpc[i]) begin
                            d.pc[i] = PWDATA[`GPPS_PC_W-1:0];
                        end
                    end
                    d.mpc = '0;
                end else begin
                    d.pc[pidx] = PWDATA[`GPPS_PC_W-1:0];
                end
            end
        end

        // Interrupt flags: a detection in the clearing cycle wins
        set = {|(hit & q.m1), |(hit & q.m0)};
        d.flags = (q.flags & ~clr) | set;
        d.int0 = q.flags[0] && q.ictl[`GPPS_ICTL_LVL0] != 2'h0;
        d.int1 = q.flags[1] && q.ictl[`GPPS_ICTL_LVL1] != 2'h0;
        d.vec0 = `GPPS_PORT_C_VECTOR_BASE + `GPPS_INT0_VEC_OFS;
        d.vec1 = `GPPS_PORT_C_VECTOR_BASE + `GPPS_INT1_VEC_OFS;
        d.wake = |wk;

        // Output drivers
        for (int i = 0; i < NPINS; i++) begin
            v = q.out[i];
            oe = q.dir[i];
            if (q.fun[`GPPS_FUN_CLK_EN] && q.fun[`GPPS_FUN_CLK_PIN] == 3'(i)) begin
                v = CLK_OUT_LEVEL;
            end
            if (q.fun[`GPPS_FUN_EV_EN] && q.fun[`GPPS_FUN_EV_PIN] == 3'(i)) begin
                v = EVCH7_LEVEL;
            end
            if (ALT_EN[i]) begin
                v = ALT_OUT[i];
                oe = ALT_OE[i];
            end
            v = v ^ q.pc[i][`GPPS_PC_INV];
            d.pu[i] = 1'b0;
            d.pd[i] = 1'b0;
            case (gpps_pkg::gpps_opc_e'(q.pc[i][`GPPS_PC_OPC]))
                gpps_pkg::GPPS_OPC_TOTEM: begin
                    drive = oe;
                end
                gpps_pkg::GPPS_OPC_KEEPER: begin
                    drive = oe;
                    d.pu[i] = !drive && q.keep[i];
                    d.pd[i] = !drive && !q.keep[i];
                end
                gpps_pkg::GPPS_OPC_PULLDOWN: begin
                    drive = oe;
                    d.pd[i] = !drive;
                end
                gpps_pkg::GPPS_OPC_PULLUP: begin
                    drive = oe;
                    d.pu[i] = !drive;
                end
                gpps_pkg::GPPS_OPC_WOR: begin
                    drive = oe && v;
                end
                gpps_pkg::GPPS_OPC_WOR_PD: begin
                    drive = oe && v;
                    d.pd[i] = !drive;
                end
                gpps_pkg::GPPS_OPC_WAND: begin
                    drive = oe && !v;
                end
                default: begin
                    drive = oe && !v;
                    d.pu[i] = !drive;
                end
            endcase
            // Keeper follows the driven level, else the level seen on the pin
            d.keep[i] = drive ? v : pin_sync[i];
            d.pin_out[i] = v;
            d.pin_oe_n[i] = !drive;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            q <= '0;
            q.pin_oe_n <= '1;
            q.vec0 <= `GPPS_PORT_C_VECTOR_BASE + `GPPS_INT0_VEC_OFS;
            q.vec1 <= `GPPS_PORT_C_VECTOR_BASE + `GPPS_INT1_VEC_OFS;
        end else begin
            q <= d;
        end
    end

    // ==========================================
    // Outputs
    assign PRDATA = q.prdata;
    assign PREADY = q.pready;
    assign PSLVERR = q.pslverr;
    assign PORT_PIN_OUT = q.pin_out;
    assign PORT_PIN_OE_N = q.pin_oe_n;
    assign PORT_PIN_PULL_UP = q.pu;
    assign PORT_PIN_PULL_DOWN = q.pd;
    assign INT0_REQ = q.int0;
    assign INT1_REQ = q.int1;
    assign INT0_LEVEL = q.ictl[`GPPS_ICTL_LVL0];
    assign INT1_LEVEL = q.ictl[`GPPS_ICTL_LVL1];
    assign INT0_VECTOR = q.vec0;
    assign INT1_VECTOR = q.vec1;
    assign SENSE_EVENT = q.evt;
    assign WAKE_REQ = q.wake;

    // ==========================================
    // Checks
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);

    a_apb_zero_wait: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("setup not followed by ready");
    a_dir_set: assert property (wr && PADDR == `GPPS_DIRSET
        |=> q.dir == ($past(q.dir) | $past(PWDATA[7:0])))
        else $error("direction set failed");
    a_out_toggle: assert property (wr && PADDR == `GPPS_OUTTGL
        |=> q.out == ($past(q.out) ^ $past(PWDATA[7:0])))
        else $error("output toggle failed");
    a_flag_raise: assert property ((hit & q.m0) != '0 ##1 1'b1 |-> q.flags[0])
        else $error("masked detection lost");
    a_int_follow: assert property (q.flags[1] && q.ictl[`GPPS_ICTL_LVL1] != 2'h0
        |=> INT1_REQ)
        else $error("interrupt not raised");
    a_int1_vector: assert property (INT1_REQ |-> INT1_VECTOR == 12'h006)
        else $error("wrong vector");
    a_mpc_clears: assert property (wr && PADDR == `GPPS_PINCTRL0 && q.mpc != '0
        |=> q.mpc == '0 && q.pc[0] == ($past(q.mpc[0]) ? $past(PWDATA[`GPPS_PC_W-1:0])
        : $past(q.pc[0])))
        else $error("multi-pin write failed");
    a_input_hiz: assert property (q.dir == '0 && ALT_EN == '0
        |=> PORT_PIN_OE_N == '1)
        else $error("input pin driven");
    a_out_inverts: assert property (ALT_EN[0] && ALT_OE[0] && q.fun == 8'h00
        && q.pc[0][`GPPS_PC_OPC] == 3'h0 |=> PORT_PIN_OUT[0] == ($past(ALT_OUT[0])
        ^ $past(q.pc[0][`GPPS_PC_INV])) && !PORT_PIN_OE_N[0])
        else $error("alternate output path wrong");
endmodule

`default_nettype wire

// [testbench/gpps_pin_model.sv]
// Board model of the eight port pins: outside drivers, pulls and floating lines
`default_nettype none

module gpps_pin_model (
    // Clock
    input wire logic clk,
    // Port side
    input wire logic [7:0] out,
    input wire logic [7:0] oe_n,
    input wire logic [7:0] pu,
    input wire logic [7:0] pd,
    // Outside drivers
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    // Resolved level
    output logic [7:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================
    // Level resolution; an undriven, unpulled line flips every cycle
    logic [7:0] last_q = 8'h00;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (ext_en[i]) pin[i] = ext_val[i];
            else if (!oe_n[i]) pin[i] = out[i];
            else if (pu[i]) pin[i] = 1'b1;
            else if (pd[i]) pin[i] = 1'b0;
            else pin[i] = ~last_q[i];
        end
    end

    always_ff @(posedge clk) begin
        last_q <= pin;
    end
endmodule

`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench of the sensing I/O port
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================
    // Signals
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, int0, int1, wake;
    logic [7:0] pin, pout, oe_n, pu, pd, sev;
    logic [7:0] alt_en = 8'h00;
    logic [7:0] alt_out = 8'h00;
    logic [7:0] alt_oe = 8'hFF;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] ext_en = 8'h00;
    logic clk_lvl = 1'b0;
    logic ev_lvl = 1'b0;
    logic pclk_en = 1'b1;
    logic [1:0] lvl0, lvl1;
    logic [11:0] vec0, vec1;
    logic [31:0] rdat;
    logic rerr;
    int failures = 0;
    int total_checks = 0;
    // Driver table: opc, dir, out, then expected oe_n, pull-up, pull-down
    logic [7:0] drv [8] = '{8'b011_00_110, 8'b010_00_101, 8'b110_11_100,
                            8'b110_10_000, 8'b100_11_000, 8'b100_10_100,
                            8'b101_10_101, 8'b111_11_110};

    always #5 clock = ~clock;

    gpps_port i_dut (.CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PORT_PIN_IN(pin), .PORT_PIN_OUT(pout),
        .PORT_PIN_OE_N(oe_n), .PORT_PIN_PULL_UP(pu), .PORT_PIN_PULL_DOWN(pd),
        .ALT_EN(alt_en), .ALT_OUT(alt_out), .ALT_OE(alt_oe), .CLK_OUT_LEVEL(clk_lvl),
        .EVCH7_LEVEL(ev_lvl), .PORT_CLK_EN(pclk_en), .INT0_REQ(int0), .INT1_REQ(int1),
        .INT0_LEVEL(lvl0), .INT1_LEVEL(lvl1), .INT0_VECTOR(vec0), .INT1_VECTOR(vec1),
        .SENSE_EVENT(sev), .WAKE_REQ(wake));

    gpps_pin_model i_pins (.clk(clock), .out(pout), .oe_n(oe_n), .pu(pu), .pd(pd),
        .ext_val(ext_val), .ext_en(ext_en), .pin(pin));

    // ==========================================
    // Tasks and expectation functions
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            failures++;
            results();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [7:0] nxt(input int op, input logic [7:0] cur, input logic [7:0] v);
        case (op)
            0: return v;
            1: return cur | v;
            2: return cur & ~v;
            default: return cur ^ v;
        endcase
    endfunction

    function automatic logic hit(input int m, input logic rise);
        case (m)
            1: return rise;
            2: return !rise;
            default: return 1'b1;
        endcase
    endfunction

    // ==========================================
    // Main sequence
    initial begin
        logic [7:0] dm, om, v, inv, r, am;
        logic f;
        int a;
        void'($urandom(32'hD930));
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        check("oe_n_rst", oe_n, 8'hFF);
        check("vec0", vec0, 12'h004);
        check("vec1", vec1, 12'h006);
        dm = 8'h00;
        om = 8'h00;
        for (int k = 0; k < 24; k++) begin
            a = k % 8;
            v = 8'($urandom());
            if (a < 4) dm = nxt(a, dm, v);
            else om = nxt(a - 4, om, v);
            apb(1'b1, 8'(a * 4), {24'h0, v});
            apb(1'b0, (a < 4) ? (k < 16 ? 8'h00 : 8'h80) : (k < 16 ? 8'h10 : 8'h84), 32'h0);
            check("rmw", rdat, (a < 4) ? dm : om);
            check("oe_n", oe_n, 8'(~dm));
            check("pin_out", pout & dm, om & dm);
        end
        check("slverr_ok", rerr, 1'b0);
        apb(1'b0, 8'hFC, 32'h0);
        check("slverr_bad", rerr, 1'b1);
        // Input inversion set on several pins in one write
        inv = 8'($urandom()) | 8'h01;
        v = 8'($urandom());
        om = 8'($urandom());
        apb(1'b1, 8'h00, 32'h0);
        ext_en <= 8'hFF;
        ext_val <= v;
        apb(1'b1, 8'h34, {24'h0, inv});
        apb(1'b1, 8'h40, 32'h20);
        tick(4);
        apb(1'b0, 8'h20, 32'h0);
        check("in", rdat, v ^ inv);
        apb(1'b0, 8'h88, 32'h0);
        check("vin", rdat, v ^ inv);
        ext_en <= 8'h00;
        apb(1'b1, 8'h00, 32'hFF);
        apb(1'b1, 8'h10, {24'h0, om});
        tick(2);
        check("pin_inv", pout, om ^ inv);
        am = 8'($urandom());
        r = 8'($urandom());
        dm = 8'($urandom());
        alt_en <= am;
        alt_out <= r;
        alt_oe <= dm;
        tick(3);
        check("alt_out", pout, ((r & am) | (om & ~am)) ^ inv);
        check("alt_oe", oe_n, am & ~dm);
        alt_en <= 8'h00;
        apb(1'b1, 8'h34, 32'hFF);
        apb(1'b1, 8'h40, 32'h0);
        // Clock output on pin 3, event channel on pin 5
        apb(1'b1, 8'h38, 32'hB7);
        for (int k = 0; k < 2; k++) begin
            clk_lvl <= k[0];
            ev_lvl <= !k[0];
            tick(3);
            check("clk_pin", pout[3], k[0]);
            check("ev_pin", pout[5], !k[0]);
        end
        apb(1'b1, 8'h38, 32'h0);
        // Driver settings on pin 2
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, 8'h48, {27'h0, drv[k][7:5], 2'b00});
            apb(1'b1, 8'h00, {29'h0, drv[k][4], 2'b00});
            apb(1'b1, 8'h10, {29'h0, drv[k][3], 2'b00});
            tick(2);
            check("driver", {oe_n[2], pu[2], pd[2]}, drv[k][2:0]);
        end
        apb(1'b1, 8'h48, 32'h04);
        for (int b = 0; b < 2; b++) begin
            apb(1'b1, 8'h10, b[0] ? 32'h04 : 32'h0);
            apb(1'b1, 8'h00, 32'h04);
            apb(1'b1, 8'h00, 32'h0);
            tick(3);
            check("keeper", {pu[2], pd[2]}, {b[0], !b[0]});
        end
        // Sensing on pin 1, both interrupts select it, the second has a level in odd modes
        apb(1'b1, 8'h24, 32'h1);
        apb(1'b1, 8'h28, 32'h2);
        apb(1'b1, 8'h2C, 32'h2);
        ext_en <= 8'h02;
        check("levels", {lvl1, lvl0}, 4'h1);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, 8'h24, m[0] ? 32'h9 : 32'h1);
            for (int s = 0; s < 2; s++) begin
                a = $urandom_range(1, 0);
                ext_val <= {6'h0, s[0], 1'b0};
                apb(1'b1, 8'h44, {26'h0, a[0], 3'b000, 2'(m)});
                tick(8);
                apb(1'b1, 8'h30, 32'h3);
                apb(1'b0, 8'h30, 32'h0);
                check("flags_idle", rdat, (m == 3 && (s[0] ^ a[0]) == 1'b0) ? 3 : 0);
                ext_val <= {6'h0, !s[0], 1'b0};
                tick(8);
                f = hit(m, !(s[0] ^ a[0]));
                check("int0", int0, f);
                check("int1", int1, f && m[0]);
                check("levels_m", {lvl1, lvl0}, m[0] ? 4'h9 : 4'h1);
                check("event", sev[1], m == 3 && (s[0] ^ a[0]));
                apb(1'b0, 8'h30, 32'h0);
                check("flags", rdat, f ? 3 : 0);
            end
        end
        // Wake-up from low-level sense with the port clock stopped
        ext_val <= 8'h02;
        apb(1'b1, 8'h44, 32'h3);
        apb(1'b1, 8'h30, 32'h3);
        check("wake_idle", wake, 1'b0);
        pclk_en <= 1'b0;
        ext_val <= 8'h00;
        tick(6);
        check("wake", wake, 1'b1);
        apb(1'b0, 8'h8C, 32'h0);
        check("flags_async", rdat, 32'h0);
        pclk_en <= 1'b1;
        tick(4);
        check("wake_end", wake, 1'b0);
        results();
    end
endmodule

`default_nettype wire
